// file: logic/usf_pkg.sv
// usf_pkg: register offsets, field positions, reset values and modes for the soft flow block
// assumes an apb slave with 32-bit data and word-aligned registers
package usf_pkg;
	localparam logic [7:0] OFS_FLOW_CTRL = 8'h50;
	localparam logic [7:0] OFS_RESUME1 = 8'h54;
	localparam logic [7:0] OFS_RESUME2 = 8'h58;
	localparam logic [7:0] OFS_PAUSE1 = 8'h5C;
	localparam logic [7:0] OFS_PAUSE2 = 8'h60;
	localparam logic [7:0] OFS_FLAG = 8'h18;
	localparam logic [7:0] OFS_LEVEL_SEL = 8'h34;
	localparam logic [7:0] OFS_MASK = 8'h38;
	localparam logic [7:0] OFS_RAW = 8'h3C;
	localparam logic [7:0] OFS_MASKED = 8'h40;
	localparam logic [7:0] OFS_CLEAR = 8'h44;
	// flow control register fields
	localparam int FC_EN = 0;
	localparam int FC_RXMODE = 1;
	localparam int FC_TXMODE = 3;
	localparam int FC_STRATEGY = 5;
	localparam int FC_ANY = 6;
	localparam int FC_SPECIAL = 7;
	localparam int FC_FIFO_EN = 8;
	// interrupt bit positions
	localparam int IRQ_TXEMPTY = 0;
	localparam int IRQ_PAUSE = 1;
	localparam int IRQ_RX = 2;
	localparam int IRQ_TX = 3;
	localparam int IRQ_TIMEOUT = 4;
	localparam int IRQ_ERROR = 5;
	localparam int IRQ_NUM = 6;
	localparam int FLAG_REMOTE_OFF = 13;
	localparam logic [1:0] MODE_OFF = 2'h0;
	localparam logic [1:0] MODE_FIRST = 2'h1;
	localparam logic [1:0] MODE_SECOND = 2'h2;
	localparam logic [1:0] MODE_BOTH = 2'h3;
	localparam logic [4:0] LEVEL_SEL_RESET = 5'h12;
endpackage

// file: logic/usf_seq_match.sv
// usf_seq_match: one- or two-character sequence matcher for pause or resume
// assumes one received character per strobe, errors on the character ignored
`timescale 1ns/1ps
module usf_seq_match
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic strobe,
	input wire logic [7:0] char_in,
	input wire logic [1:0] mode,
	input wire logic [7:0] first_char,
	input wire logic [7:0] second_char,
	input wire logic clear,
	output logic hit,
	output logic part
);
	logic half_r;
	logic eq1;
	logic eq2;
	assign eq1 = char_in == first_char;
	assign eq2 = char_in == second_char;
	always_comb
	begin
		hit = 1'b0;
		part = 1'b0;
		if (strobe)
		begin
			unique case (mode)
				usf_pkg::MODE_OFF: hit = 1'b0;
				usf_pkg::MODE_FIRST: hit = eq1;
				usf_pkg::MODE_SECOND: hit = eq2;
				usf_pkg::MODE_BOTH:
				begin
					hit = half_r && eq2;
					part = eq1 || (half_r && eq2);
				end
			endcase
		end
	end
	// a broken sequence restarts from its first character [RULE23]
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			half_r <= 1'b0;
		else if (clear || mode != usf_pkg::MODE_BOTH)
			half_r <= 1'b0;
		else if (strobe)
			half_r <= eq1 && !(half_r && eq2);
	end
endmodule

// file: logic/usf_top.sv
// usf_top: in-band pause/resume flow control and interrupt merge for a serial port
// assumes the transmitter, receiver and fifos sit outside and report through plain ports
// Overview of operation
// [RULE1] flow control acts only while the enable bit is set
// [RULE2] receive mode picks first pair, second pair or both in sequence
// [RULE3] pause match halts transmitter after current character and sets pause flag
// [RULE4] unmasked pause flag shows in masked status and drives interrupt
// [RULE5] while paused, resume match clears pause flag and restarts transmitter
// [RULE6] any-character-resumes makes every character resume, and it is stored
// [RULE7] matched pause and resume characters are not stored, with two exceptions
// [RULE8] line errors on a character do not stop it matching
// [RULE9] transmit mode picks which pair is inserted automatically
// [RULE10] fifo over trigger level inserts a pause and sets remote-off flag
// [RULE11] fifo below trigger level after a pause inserts a resume, clears flag
// [RULE12] disabling flow control after a pause sends a resume and clears flag
// [RULE13] inserted characters use the normal transmit framing
// [RULE14] software polls remote-off before reading the receive fifo
// [RULE15] software never enables hardware and in-band flow control together
// [RULE16] special-character mode matches second pause value, flow control off
// [RULE17] special match neither halts nor drops; cleared by writing one
// [RULE18] six maskable sources merge into one output, raw and masked readable
// [RULE19] mask bit one enables a source, zero disables it
// [RULE20] tx-empty interrupt rises when busy falls
// [RULE21] receive interrupt follows trigger level or holding register, clearable
// [RULE22] transmit interrupt is edge triggered below watermark or on empty
// [RULE23] a broken two-character sequence restarts from its first character
//
// Our own choices: the address map and register access over APB.
`timescale 1ns/1ps
module usf_top
(
	input wire logic CORE_CLK,
	input wire logic RESET_N,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic RX_STROBE,
	input wire logic [7:0] RX_CHAR,
	output logic RX_STORE,
	input wire logic [4:0] RX_FILL,
	input wire logic [4:0] RX_TRIGGER,
	input wire logic [4:0] TX_FILL,
	input wire logic [4:0] TX_WATERMARK,
	input wire logic TX_BUSY,
	input wire logic TX_CHAR_DONE,
	output logic TX_HALT,
	output logic TX_INSERT_VALID,
	output logic [7:0] TX_INSERT_CHAR,
	input wire logic TX_INSERT_TAKEN,
	input wire logic TIMEOUT_EVENT,
	input wire logic ERROR_EVENT,
	output logic UART_IRQ
);
	logic [8:0] flow_ctrl_r;
	logic [7:0] resume1_r;
	logic [7:0] resume2_r;
	logic [7:0] pause1_r;
	logic [7:0] pause2_r;
	logic [4:0] level_sel_r;
	logic [5:0] mask_r;
	logic [5:0] raw_r;
	logic paused_r;
	logic halt_r;
	logic remote_off_r;
	logic pend_pause_r;
	logic pend_resume_r;
	logic [7:0] ins_char_r;
	logic ins_valid_r;
	logic ins_second_r;
	logic busy_d_r;
	logic rx_over_d_r;
	logic tx_below_d_r;
	logic tx_written_r;
	logic wr;
	logic rd;
	logic sw_en;
	logic special;
	logic [1:0] rx_mode;
	logic [1:0] tx_mode;
	logic [5:0] clr;
	logic pause_hit;
	logic pause_part;
	logic resume_hit;
	logic resume_part;
	logic any_resume;
	logic special_hit;
	logic rx_over;
	logic tx_below;
	logic [5:0] set;
	logic [1:0] strat_mode;
	assign wr = PSEL && PENABLE && PWRITE;
	assign rd = PSEL && !PWRITE;
	assign special = flow_ctrl_r[usf_pkg::FC_SPECIAL];
	// special-character detection switches flow control off [RULE16] [RULE1]
	assign sw_en = flow_ctrl_r[usf_pkg::FC_EN] && !special;
	assign rx_mode = sw_en ? flow_ctrl_r[usf_pkg::FC_RXMODE +: 2] : usf_pkg::MODE_OFF; // [RULE2]
	assign tx_mode = sw_en ? flow_ctrl_r[usf_pkg::FC_TXMODE +: 2] : usf_pkg::MODE_OFF; // [RULE9]
	// strategy bit set: resume checks both pairs in every receive mode except off
	assign strat_mode = flow_ctrl_r[usf_pkg::FC_STRATEGY] && rx_mode != usf_pkg::MODE_OFF
		? usf_pkg::MODE_BOTH : rx_mode;
	assign clr = (wr && PADDR == usf_pkg::OFS_CLEAR) ? PWDATA[5:0] : 6'h00;
	// matches look only at the character, never its error bits [RULE8]
	usf_seq_match u_pause
	(
		.clk(CORE_CLK),
		.rst_n(RESET_N),
		.strobe(RX_STROBE && !paused_r),
		.char_in(RX_CHAR),
		.mode(rx_mode),
		.first_char(pause1_r),
		.second_char(pause2_r),
		.clear(paused_r),
		.hit(pause_hit),
		.part(pause_part)
	);
	usf_seq_match u_resume
	(
		.clk(CORE_CLK),
		.rst_n(RESET_N),
		.strobe(RX_STROBE && paused_r),
		.char_in(RX_CHAR),
		.mode(strat_mode),
		.first_char(resume1_r),
		.second_char(resume2_r),
		.clear(!paused_r),
		.hit(resume_hit),
		.part(resume_part)
	);
	assign any_resume = RX_STROBE && paused_r && flow_ctrl_r[usf_pkg::FC_ANY]; // [RULE6]
	assign special_hit = special && RX_STROBE && RX_CHAR == pause2_r; // [RULE16]
	// store unless the character belongs to a pause or resume match, except the character that any-resume lets resume and in special mode [RULE7] [RULE17]
	assign RX_STORE = RX_STROBE && (any_resume || special
		|| !(pause_hit || pause_part || resume_hit || resume_part));
	// pause state and halt of the local transmitter
	always_ff @(posedge CORE_CLK or negedge RESET_N)
	begin
		if (!RESET_N)
			paused_r <= 1'b0;
		else if (!sw_en || resume_hit || any_resume)
			paused_r <= 1'b0; // [RULE5] [RULE6]
		else if (pause_hit)
			paused_r <= 1'b1; // [RULE3]
	end
	// halt is raised when the current character ends, so it is never cut short
	always_ff @(posedge CORE_CLK or negedge RESET_N)
	begin
		if (!RESET_N)
			halt_r <= 1'b0;
		// drops on the same edge as the pause, so halt never outlives it
		else if (!paused_r || !sw_en || resume_hit || any_resume)
			halt_r <= 1'b0;
		else if (!TX_BUSY || TX_CHAR_DONE)
			halt_r <= 1'b1; // [RULE3]
	end
	assign TX_HALT = halt_r;
	// automatic insertion on receive fill level
	assign rx_over = RX_FILL >= RX_TRIGGER;
	always_ff @(posedge CORE_CLK or negedge RESET_N)
	begin
		if (!RESET_N)
			rx_over_d_r <= 1'b0;
		else
			rx_over_d_r <= rx_over;
	end
	always_ff @(posedge CORE_CLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			pend_pause_r <= 1'b0;
			pend_resume_r <= 1'b0;
		end
		else
		begin
			if (tx_mode != usf_pkg::MODE_OFF && rx_over && !rx_over_d_r && !remote_off_r)
				pend_pause_r <= 1'b1; // [RULE10]
			else if (ins_valid_r && TX_INSERT_TAKEN && !ins_second_r && !pend_resume_r)
				pend_pause_r <= 1'b0;
			if (remote_off_r && !ins_valid_r && (tx_mode == usf_pkg::MODE_OFF || !rx_over))
				pend_resume_r <= 1'b1; // [RULE11] [RULE12]
			else if (ins_valid_r && TX_INSERT_TAKEN && !ins_second_r)
				pend_resume_r <= 1'b0;
		end
	end
	// insertion goes through the normal transmitter, so framing matches data [RULE13]
	always_ff @(posedge CORE_CLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			ins_valid_r <= 1'b0;
			ins_char_r <= 8'h00;
			ins_second_r <= 1'b0;
			remote_off_r <= 1'b0;
		end
		else if (ins_valid_r)
		begin
			if (TX_INSERT_TAKEN)
			begin
				if (ins_second_r)
				begin
					ins_char_r <= pend_resume_r ? resume2_r : pause2_r;
					ins_second_r <= 1'b0;
				end
				else
				begin
					ins_valid_r <= 1'b0;
					remote_off_r <= !pend_resume_r; // [RULE10] [RULE11]
				end
			end
		end
		else if (pend_resume_r)
		begin
			ins_valid_r <= 1'b1;
			ins_char_r <= flow_ctrl_r[usf_pkg::FC_TXMODE +: 2] == usf_pkg::MODE_SECOND
				? resume2_r : resume1_r;
			ins_second_r <= flow_ctrl_r[usf_pkg::FC_TXMODE +: 2] == usf_pkg::MODE_BOTH;
		end
		else if (pend_pause_r)
		begin
			ins_valid_r <= 1'b1;
			ins_char_r <= tx_mode == usf_pkg::MODE_SECOND ? pause2_r : pause1_r;
			ins_second_r <= tx_mode == usf_pkg::MODE_BOTH;
		end
	end
	assign TX_INSERT_VALID = ins_valid_r;
	assign TX_INSERT_CHAR = ins_char_r;
	// interrupt events
	assign tx_below = flow_ctrl_r[usf_pkg::FC_FIFO_EN] ? TX_FILL < TX_WATERMARK : TX_FILL == 5'h00;
	always_ff @(posedge CORE_CLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			busy_d_r <= 1'b0;
			tx_below_d_r <= 1'b0;
			tx_written_r <= 1'b0;
		end
		else
		begin
			busy_d_r <= TX_BUSY;
			tx_below_d_r <= tx_below;
			if (TX_FILL != 5'h00)
				tx_written_r <= 1'b1;
		end
	end
	always_comb
	begin
		set = 6'h00;
		set[usf_pkg::IRQ_TXEMPTY] = busy_d_r && !TX_BUSY; // [RULE20]
		set[usf_pkg::IRQ_PAUSE] = pause_hit || special_hit; // [RULE3] [RULE16]
		// without fifos the flag simply follows the holding register
		set[usf_pkg::IRQ_RX] = flow_ctrl_r[usf_pkg::FC_FIFO_EN]
			? rx_over && !rx_over_d_r : RX_FILL != 5'h00; // [RULE21]
		set[usf_pkg::IRQ_TX] = tx_below && !tx_below_d_r && tx_written_r; // [RULE22]
		set[usf_pkg::IRQ_TIMEOUT] = TIMEOUT_EVENT;
		set[usf_pkg::IRQ_ERROR] = ERROR_EVENT;
	end
	// set wins over any clear in the same cycle
	always_ff @(posedge CORE_CLK or negedge RESET_N)
	begin
		if (!RESET_N)
			raw_r <= 6'h00;
		else
		begin
			raw_r <= (raw_r & ~clr) | set; // [RULE17]
			if (!set[usf_pkg::IRQ_PAUSE] && (resume_hit || any_resume))
				raw_r[usf_pkg::IRQ_PAUSE] <= 1'b0; // [RULE5]
			if (!set[usf_pkg::IRQ_RX] && (!rx_over || !flow_ctrl_r[usf_pkg::FC_FIFO_EN]))
				raw_r[usf_pkg::IRQ_RX] <= 1'b0; // [RULE21]
			if (!set[usf_pkg::IRQ_TX] && !tx_below)
				raw_r[usf_pkg::IRQ_TX] <= 1'b0; // [RULE22]
		end
	end
	assign UART_IRQ = |(raw_r & mask_r); // [RULE4] [RULE18] [RULE19]
	// register writes
	always_ff @(posedge CORE_CLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			flow_ctrl_r <= 9'h000;
			resume1_r <= 8'h00;
			resume2_r <= 8'h00;
			pause1_r <= 8'h00;
			pause2_r <= 8'h00;
			level_sel_r <= usf_pkg::LEVEL_SEL_RESET;
			mask_r <= 6'h00;
		end
		else if (wr)
		begin
			unique case (PADDR)
				usf_pkg::OFS_FLOW_CTRL: flow_ctrl_r <= PWDATA[8:0];
				usf_pkg::OFS_RESUME1: resume1_r <= PWDATA[7:0];
				usf_pkg::OFS_RESUME2: resume2_r <= PWDATA[7:0];
				usf_pkg::OFS_PAUSE1: pause1_r <= PWDATA[7:0];
				usf_pkg::OFS_PAUSE2: pause2_r <= PWDATA[7:0];
				usf_pkg::OFS_LEVEL_SEL: level_sel_r <= PWDATA[4:0];
				usf_pkg::OFS_MASK: mask_r <= PWDATA[5:0]; // [RULE19]
				default: ;
			endcase
		end
	end
	// read data registered in the setup cycle, one wait-free access phase
	always_ff @(posedge CORE_CLK or negedge RESET_N)
	begin
		if (!RESET_N)
			PRDATA <= 32'h0000_0000;
		else if (rd && !PENABLE)
		begin
			unique case (PADDR)
				usf_pkg::OFS_FLOW_CTRL: PRDATA <= {23'h0, flow_ctrl_r};
				usf_pkg::OFS_RESUME1: PRDATA <= {24'h0, resume1_r};
				usf_pkg::OFS_RESUME2: PRDATA <= {24'h0, resume2_r};
				usf_pkg::OFS_PAUSE1: PRDATA <= {24'h0, pause1_r};
				usf_pkg::OFS_PAUSE2: PRDATA <= {24'h0, pause2_r};
				usf_pkg::OFS_LEVEL_SEL: PRDATA <= {27'h0, level_sel_r};
				usf_pkg::OFS_MASK: PRDATA <= {26'h0, mask_r};
				usf_pkg::OFS_RAW: PRDATA <= {26'h0, raw_r}; // [RULE18]
				usf_pkg::OFS_MASKED: PRDATA <= {26'h0, raw_r & mask_r};
				usf_pkg::OFS_FLAG: PRDATA <= 32'(remote_off_r) << usf_pkg::FLAG_REMOTE_OFF;
				default: PRDATA <= 32'h0000_0000;
			endcase
		end
	end
	assign PREADY = 1'b1;
	assign PSLVERR = 1'b0;

	AST_HALT_ONLY_PAUSED: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
		TX_HALT |-> paused_r) else $error("halt without pause"); // [RULE3]
	AST_PAUSE_FLAG: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
		pause_hit |=> raw_r[usf_pkg::IRQ_PAUSE]) else $error("pause flag not set"); // [RULE3]
	AST_IRQ_MERGE: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
		(raw_r[1] && mask_r[1]) |-> UART_IRQ) else $error("irq not raised"); // [RULE4]
	AST_RESUME_CLEARS: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
		(resume_hit && !pause_hit) |=> !paused_r && !raw_r[1]) else $error("resume failed"); // [RULE5]
	AST_ANY_STORE: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
		any_resume |-> RX_STORE) else $error("any resume char dropped"); // [RULE6]
	AST_MATCH_DROP: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
		(pause_hit && !special) |-> !RX_STORE) else $error("pause char stored"); // [RULE7]
	AST_OFF_NO_MATCH: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
		!flow_ctrl_r[0] |-> !pause_hit) else $error("match while disabled"); // [RULE1]
	AST_TXEMPTY: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
		$fell(TX_BUSY) |=> raw_r[usf_pkg::IRQ_TXEMPTY]) else $error("tx empty missed"); // [RULE20]
	AST_SPECIAL_NOHALT: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
		special |=> !paused_r) else $error("special halted"); // [RULE17]
	COV_PAUSE: cover property (@(posedge CORE_CLK) disable iff (!RESET_N) $rose(TX_HALT));
	COV_INSERT: cover property (@(posedge CORE_CLK) disable iff (!RESET_N)
		TX_INSERT_VALID && TX_INSERT_TAKEN);
	COV_SPECIAL: cover property (@(posedge CORE_CLK) disable iff (!RESET_N) special_hit);
endmodule

// file: tb/usf_far_end.sv
// usf_far_end: remote serial transceiver at the block's character ports
// assumes one clock; characters come as one-cycle strobes
`timescale 1ns/1ps
module usf_far_end
(
	input wire logic clk,
	output logic rx_strobe,
	output logic [7:0] rx_char,
	input wire logic rx_store,
	input wire logic ins_valid,
	input wire logic [7:0] ins_char,
	output logic ins_taken
);
	logic [7:0] got[$];
	int n_store = 0;
	int lag = 0;
	int wait_n = 0;
	initial
	begin
		rx_strobe = 1'b0;
		rx_char = 8'h00;
		ins_taken = 1'b0;
	end
	// data inverted between frames, so a stale value never matches
	task automatic send(input logic [7:0] c);
		@(posedge clk);
		rx_strobe <= 1'b1;
		rx_char <= c;
		@(posedge clk);
		if (rx_store === 1'b1)
			n_store++;
		rx_strobe <= 1'b0;
		rx_char <= ~c;
	endtask
	// slow or prompt acceptance, set by lag
	always @(posedge clk)
	begin
		if (ins_taken)
		begin
			got.push_back(ins_char);
			ins_taken <= 1'b0;
			wait_n <= 0;
		end
		else if (ins_valid === 1'b1)
		begin
			if (wait_n >= lag)
				ins_taken <= 1'b1;
			else
				wait_n <= wait_n + 1;
		end
	end
endmodule

// file: tb/tb_top.sv
// tb_top: self-checking bench for the in-band flow control block
// assumes usf_pkg offsets and a zero-wait apb slave
`timescale 1ns/1ps
module tb_top;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic pen = 1'b0;
	logic pwr = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, q;
	logic pready, pslverr, rx_stb, rx_store, tx_halt, ins_v, ins_t, irq;
	logic tx_done = 1'b0;
	logic [4:0] tx_fill = 5'h00;
	logic [7:0] rx_char, ins_c;
	logic [4:0] rx_fill = 5'h00;
	logic tx_busy = 1'b0;
	logic tmo = 1'b0;
	logic err = 1'b0;
	int n_fail = 0;
	int checked = 0;
	localparam logic [7:0] P1 = 8'h13, P2 = 8'h93, R1 = 8'h11, R2 = 8'h91;
	always #5 clk = ~clk;
	usf_top i_dut(.CORE_CLK(clk), .RESET_N(rst_n), .PSEL(psel), .PENABLE(pen),
		.PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .RX_STROBE(rx_stb), .RX_CHAR(rx_char), .RX_STORE(rx_store),
		.RX_FILL(rx_fill), .RX_TRIGGER(5'h08), .TX_FILL(tx_fill), .TX_WATERMARK(5'h00),
		.TX_BUSY(tx_busy), .TX_CHAR_DONE(tx_done), .TX_HALT(tx_halt), .TX_INSERT_VALID(ins_v),
		.TX_INSERT_CHAR(ins_c), .TX_INSERT_TAKEN(ins_t), .TIMEOUT_EVENT(tmo),
		.ERROR_EVENT(err), .UART_IRQ(irq));
	usf_far_end i_far(.clk(clk), .rx_strobe(rx_stb), .rx_char(rx_char), .rx_store(rx_store),
		.ins_valid(ins_v), .ins_char(ins_c), .ins_taken(ins_t));
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e)
		begin
			$display("mismatch %s expected %h seen %h", n, e, g);
			n_fail++;
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		do
			@(posedge clk);
		while (pready !== 1'b1);
		q = prdata;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	task automatic bit_is(input string n, input logic [7:0] a, input int b, input logic e);
		apb(1'b0, a, 32'h0);
		chk(n, e, q[b]);
	endtask
	task automatic halt_is(input logic e);
		for (int i = 0; i < 8 && tx_halt !== e; i++)
			@(posedge clk);
		chk("halt", e, tx_halt);
	endtask
	task automatic seq(input int m, input logic [7:0] a, input logic [7:0] b);
		if (m[0])
			i_far.send(a);
		if (m[1])
			i_far.send(b);
	endtask
	task automatic wait_got(input int n);
		for (int i = 0; i < 100 && i_far.got.size() < n; i++)
			@(posedge clk);
		chk("insert count", n, i_far.got.size());
	endtask
	// x: bit0 strategy, bit1 any resumes, bit2 special detect
	function automatic logic [31:0] fc(input int rx, input int tx, input int x);
		return 32'(1 + (rx << usf_pkg::FC_RXMODE) + (tx << usf_pkg::FC_TXMODE)
			+ (x << usf_pkg::FC_STRATEGY));
	endfunction
	task automatic t_regs();
		apb(1'b0, usf_pkg::OFS_FLOW_CTRL, 32'h0);
		chk("flow reset", 32'h0, q);
		apb(1'b0, usf_pkg::OFS_PAUSE2, 32'h0);
		chk("pause2", P2, q);
		apb(1'b1, 8'h08, 32'hFFFFFFFF);
		chk("slverr", 1'b0, pslverr);
		apb(1'b0, 8'h08, 32'h0);
		chk("unmapped", 32'h0, q);
	endtask
	task automatic t_rx();
		int s;
		for (int m = 0; m < 4; m++)
		begin
			apb(1'b1, usf_pkg::OFS_FLOW_CTRL, fc(m, 0, 0));
			apb(1'b1, usf_pkg::OFS_MASK, 32'h2);
			s = i_far.n_store;
			seq(m, P1, P2);
			if (m == 0)
				i_far.send(P1);
			halt_is(m != 0);
			chk("pause kept", s + (m == 0), i_far.n_store);
			bit_is("masked pause", usf_pkg::OFS_MASKED, 1, m != 0);
			chk("irq", m != 0, irq);
			seq(m, R1, R2);
			halt_is(1'b0);
			bit_is("raw pause", usf_pkg::OFS_RAW, 1, 1'b0);
			chk("irq off", 1'b0, irq);
			chk("resume kept", s + (m == 0), i_far.n_store);
		end
		apb(1'b1, usf_pkg::OFS_FLOW_CTRL, fc(1, 0, 0) & ~32'h1);
		s = i_far.n_store;
		i_far.send(P1);
		halt_is(1'b0);
		chk("off kept", s + 1, i_far.n_store);
	endtask
	task automatic t_break();
		apb(1'b1, usf_pkg::OFS_FLOW_CTRL, fc(3, 0, 0));
		seq(3, P1, 8'h41);
		i_far.send(P2);
		halt_is(1'b0);
		seq(3, P1, P2);
		halt_is(1'b1);
		seq(3, R1, R2);
		halt_is(1'b0);
	endtask
	task automatic t_any();
		int s;
		apb(1'b1, usf_pkg::OFS_FLOW_CTRL, fc(1, 0, 2));
		tx_busy <= 1'b1;
		i_far.send(P1);
		repeat (3) @(posedge clk);
		chk("halt busy", 1'b0, tx_halt);
		tx_done <= 1'b1;
		@(posedge clk);
		tx_done <= 1'b0;
		tx_busy <= 1'b0;
		halt_is(1'b1);
		s = i_far.n_store;
		i_far.send(8'h41);
		halt_is(1'b0);
		chk("any kept", s + 1, i_far.n_store);
	endtask
	task automatic t_special();
		int s;
		apb(1'b1, usf_pkg::OFS_FLOW_CTRL, fc(1, 0, 4));
		apb(1'b1, usf_pkg::OFS_MASK, 32'h2);
		s = i_far.n_store;
		seq(3, P1, P2);
		halt_is(1'b0);
		chk("special kept", s + 2, i_far.n_store);
		bit_is("raw special", usf_pkg::OFS_RAW, 1, 1'b1);
		chk("irq special", 1'b1, irq);
		apb(1'b1, usf_pkg::OFS_CLEAR, 32'h2);
		bit_is("special clear", usf_pkg::OFS_RAW, 1, 1'b0);
	endtask
	task automatic t_ins();
		for (int m = 1; m < 5; m++)
		begin
			i_far.got.delete();
			i_far.lag = m;
			apb(1'b1, usf_pkg::OFS_FLOW_CTRL, fc(0, m % 4 + (m == 4), 0));
			@(posedge clk);
			rx_fill <= 5'h09;
			wait_got(1 + (m == 3));
			chk("pause sent", (m == 2) ? P2 : P1, i_far.got[0]);
			if (m == 3)
				chk("pause 2nd", P2, i_far.got[1]);
			// polled before the receive side is drained
			bit_is("remote off", usf_pkg::OFS_FLAG, usf_pkg::FLAG_REMOTE_OFF, 1'b1);
			i_far.got.delete();
			if (m == 4)
				apb(1'b1, usf_pkg::OFS_FLOW_CTRL, 32'h0);
			@(posedge clk);
			rx_fill <= 5'h07;
			wait_got(1 + (m == 3));
			chk("resume sent", (m == 2) ? R2 : R1, i_far.got[0]);
			if (m == 3)
				chk("resume 2nd", R2, i_far.got[1]);
			bit_is("remote on", usf_pkg::OFS_FLAG, usf_pkg::FLAG_REMOTE_OFF, 1'b0);
		end
	endtask
	task automatic t_irq();
		apb(1'b1, usf_pkg::OFS_MASK, 32'h10);
		@(posedge clk);
		tmo <= 1'b1;
		@(posedge clk);
		tmo <= 1'b0;
		bit_is("masked timeout", usf_pkg::OFS_MASKED, usf_pkg::IRQ_TIMEOUT, 1'b1);
		chk("irq timeout", 1'b1, irq);
		apb(1'b1, usf_pkg::OFS_CLEAR, 32'h10);
		@(posedge clk);
		chk("irq cleared", 1'b0, irq);
		apb(1'b1, usf_pkg::OFS_MASK, 32'h0);
		@(posedge clk);
		err <= 1'b1;
		@(posedge clk);
		err <= 1'b0;
		bit_is("raw error", usf_pkg::OFS_RAW, usf_pkg::IRQ_ERROR, 1'b1);
		bit_is("masked error", usf_pkg::OFS_MASKED, usf_pkg::IRQ_ERROR, 1'b0);
		chk("irq masked", 1'b0, irq);
		@(posedge clk);
		tx_busy <= 1'b1;
		@(posedge clk);
		tx_busy <= 1'b0;
		bit_is("tx empty", usf_pkg::OFS_RAW, usf_pkg::IRQ_TXEMPTY, 1'b1);
		bit_is("tx untouched", usf_pkg::OFS_RAW, usf_pkg::IRQ_TX, 1'b0);
		@(posedge clk);
		tx_fill <= 5'h01;
		@(posedge clk);
		tx_fill <= 5'h00;
		bit_is("tx emptied", usf_pkg::OFS_RAW, usf_pkg::IRQ_TX, 1'b1);
		tx_fill <= 5'h01;
		bit_is("tx refilled", usf_pkg::OFS_RAW, usf_pkg::IRQ_TX, 1'b0);
		apb(1'b1, usf_pkg::OFS_FLOW_CTRL, 32'h100);
		rx_fill <= 5'h08;
		bit_is("rx level", usf_pkg::OFS_RAW, usf_pkg::IRQ_RX, 1'b1);
		rx_fill <= 5'h07;
		bit_is("rx drained", usf_pkg::OFS_RAW, usf_pkg::IRQ_RX, 1'b0);
		rx_fill <= 5'h08;
		apb(1'b1, usf_pkg::OFS_CLEAR, 32'h4);
		bit_is("rx clear", usf_pkg::OFS_RAW, usf_pkg::IRQ_RX, 1'b0);
	endtask
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// only in-band flow control is ever enabled here
	initial
	begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		apb(1'b1, usf_pkg::OFS_PAUSE1, P1);
		apb(1'b1, usf_pkg::OFS_PAUSE2, P2);
		apb(1'b1, usf_pkg::OFS_RESUME1, R1);
		apb(1'b1, usf_pkg::OFS_RESUME2, R2);
		t_regs();
		t_rx();
		t_break();
		t_any();
		t_special();
		t_ins();
		t_irq();
		final_report();
	end
	initial
	begin
		repeat (20000) @(posedge clk);
		n_fail++;
		final_report();
	end
endmodule
